// *** system_control_coproc_regmap.sv ***
// register decoder and storage of the system control coprocessor
// assumes the core holds each request for one cycle and waits for cop_done
`timescale 1ns/1ps
`default_nettype none
module system_control_coproc_regmap #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [3:0] VARIANT = 4'h0,
	parameter logic [11:0] PART_CODE = 12'h123, // arbitrary value
	parameter logic [3:0] REVISION = 4'h0,
	parameter logic [3:0] ICACHE_SIZE = 4'h5,
	parameter logic [3:0] DCACHE_SIZE = 4'h5,
	parameter logic [3:0] ITCM_SIZE = 4'h5,
	parameter logic [3:0] DTCM_SIZE = 4'h5
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic vector_high_init_input,
	input wire logic cop_valid,
	input wire logic [2:0] cop_kind,
	input wire logic [3:0] cop_num,
	input wire logic [2:0] cop_opc1,
	input wire logic [3:0] primary_reg_select,
	input wire logic [3:0] secondary_reg_select,
	input wire logic [2:0] cop_opc2,
	input wire logic cop_priv,
	input wire logic [scc_pkg::WORD_W-1:0] cop_wdata,
	output logic cop_done,
	output logic [scc_pkg::WORD_W-1:0] cop_rdata,
	output logic undefined_trap_access,
	output logic [scc_pkg::WORD_W-1:0] ctrl_word,
	output logic cache_op_valid,
	output logic [6:0] cache_op_sel,
	output logic [scc_pkg::WORD_W-1:0] cache_op_data,
	input wire logic mem_start,
	input wire logic [scc_pkg::WORD_W-1:0] base_in,
	input wire logic data_abort,
	output logic base_restore_valid,
	output logic [scc_pkg::WORD_W-1:0] base_restore_value,
	input wire logic dbg_rx_valid,
	input wire logic [scc_pkg::WORD_W-1:0] dbg_rx_data,
	input wire logic dbg_tx_taken,
	output logic dbg_tx_valid,
	output logic [scc_pkg::WORD_W-1:0] dbg_tx_data
);
	import scc_pkg::*;

	if (ICACHE_SIZE > SIZE_MAX || DCACHE_SIZE > SIZE_MAX ||
		ITCM_SIZE > SIZE_MAX || DTCM_SIZE > SIZE_MAX) begin : g_chk
		$error("size code out of range");
	end

	typedef logic [WORD_W-1:0] word_t;

	// R05 slot decode within a number
	function automatic logic [5:0] slot_of(input logic [3:0] n,
		input logic [3:0] m, input logic [2:0] o);
		logic z;
		logic lo;
		z = (m == 4'h0) && (o == 3'h0);
		lo = (o[2:1] == 2'h0);
		slot_of = 6'h00;
		unique case (n)
		REG_CTRL: slot_of = {z, SLOT_CTRL};
		// R12 instruction and data halves
		REG_CFG: slot_of = {(m == 4'h0) && lo, 5'(SLOT_CFG_D + o[0])};
		REG_WB: slot_of = {z, SLOT_WB};
		REG_AP: slot_of = {(m == 4'h0) && lo, 5'(SLOT_AP_D + o[0])};
		REG_REGION: slot_of = {!m[3] && (o == 3'h0),
			5'(SLOT_REGION0 + m[2:0])};
		REG_LOCK: slot_of = {(m[3:1] == 3'h0) && lo,
			5'(SLOT_LOCK_D + {m[0], o[0]})};
		REG_PID: slot_of = {z, SLOT_PID};
		REG_TEST: slot_of = {(m == 4'h0) && (o < 3'h3),
			5'(SLOT_BIST + o[1:0])};
		default: slot_of = 6'h00;
		endcase
	endfunction

	word_t regs_ff [NUM_SLOTS];
	logic strap_done_ff;
	logic done_ff, undef_ff, cop_ff, txv_ff, rxf_ff, brv_ff;
	word_t rdata_ff, cop_data_ff, saved_ff, brval_ff, tx_ff, rx_ff;
	logic [6:0] cop_sel_ff;

	// R02 R03 privilege and class checks
	wire take = cop_valid && (cop_num == CP_SYS || cop_num == CP_DBG);
	wire is_mcr = cop_kind == K_CORE_TO_COPROC_MOVE;
	wire is_mrc = cop_kind == K_COPROC_TO_CORE_MOVE;
	wire undef = take && (!(is_mcr || is_mrc) ||
		(cop_num == CP_SYS && !cop_priv));
	wire ok = take && !undef;
	wire sys_ok = ok && cop_num == CP_SYS && cop_opc1 == 3'h0;
	wire dbg_ok = ok && cop_num == CP_DBG;
	// R04 primary register number
	wire [5:0] slot = slot_of(primary_reg_select, secondary_reg_select,
		cop_opc2);
	wire hit = sys_ok && slot[5];
	wire wr_hit = hit && is_mcr;
	wire cop_wr = sys_ok && is_mcr && primary_reg_select == REG_CACHEOP;

	// R11 identification word layout
	wire word_t id_word = {MAKER_CODE, VARIANT, ID_ARCH, PART_CODE, REVISION};
	wire i_abs = ICACHE_SIZE == 4'h0;
	wire d_abs = DCACHE_SIZE == 4'h0;
	wire word_t ct_word = {3'h0, CT_CLASS, 1'b1, 2'h0, DCACHE_SIZE,
		d_abs ? ASSOC_NONE : ASSOC_4WAY, d_abs, CT_LINE8, 2'h0,
		ICACHE_SIZE, i_abs ? ASSOC_NONE : ASSOC_4WAY, i_abs, CT_LINE8};
	wire word_t tcm_word = {10'h000, DTCM_SIZE, 3'h0, DTCM_SIZE == 4'h0,
		4'h0, ITCM_SIZE, 3'h0, ITCM_SIZE == 4'h0, 2'h0};
	// R09 R10 R19 register 0 selection
	wire word_t info_rd = cop_opc2 == OPC2_CACHE_TYPE ? ct_word :
		cop_opc2 == OPC2_TCM_SIZE ? tcm_word : id_word;
	// R16 memory region reports the fitted size
	wire word_t slot_rd = slot[4:0] == SLOT_TCM_D ?
		{regs_ff[SLOT_TCM_D][WORD_W-1:TCM_SIZE_LSB+TCM_SIZE_W], DTCM_SIZE,
		regs_ff[SLOT_TCM_D][TCM_SIZE_LSB-1:0]} :
		slot[4:0] == SLOT_TCM_I ?
		{regs_ff[SLOT_TCM_I][WORD_W-1:TCM_SIZE_LSB+TCM_SIZE_W], ITCM_SIZE,
		regs_ff[SLOT_TCM_I][TCM_SIZE_LSB-1:0]} :
		regs_ff[slot[4:0]];
	// R18 debug comms channel status and data
	wire word_t dbg_rd = primary_reg_select == DBG_STATUS ?
		{30'h0, txv_ff, rxf_ff} :
		primary_reg_select == DBG_DATA ? rx_ff : '0;
	// R13 unreadable numbers answer zero
	wire word_t nxt_rdata = !(ok && is_mrc) ? '0 : dbg_ok ? dbg_rd :
		sys_ok && primary_reg_select == REG_INFO ? info_rd :
		hit ? slot_rd : '0;
	wire dbg_wr = dbg_ok && is_mcr && primary_reg_select == DBG_DATA;
	wire dbg_rd_data = dbg_ok && is_mrc && primary_reg_select == DBG_DATA;
	wire nxt_txv = (dbg_wr && !txv_ff) || (txv_ff && !dbg_tx_taken);
	wire nxt_rxf = (dbg_rx_valid && !rxf_ff) || (rxf_ff && !dbg_rd_data);

	// R07 R08 R09 R14 R17 R20 stateful registers, register 0 unwritable
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				regs_ff[i] <= '0;
			end
			strap_done_ff <= 1'b0;
		end else begin
			strap_done_ff <= 1'b1;
			if (wr_hit) begin
				regs_ff[slot[4:0]] <= cop_wdata;
			end
			if (!strap_done_ff) begin
				regs_ff[SLOT_CTRL][CTRL_VEC_BIT] <= vector_high_init_input;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			done_ff <= 1'b0;
			undef_ff <= 1'b0;
			rdata_ff <= '0;
			cop_ff <= 1'b0;
			cop_sel_ff <= '0;
			cop_data_ff <= '0;
		end else begin
			done_ff <= take;
			undef_ff <= undef;
			rdata_ff <= nxt_rdata;
			// R13 register 7 writes start cache operations
			cop_ff <= cop_wr;
			cop_sel_ff <= {secondary_reg_select, cop_opc2};
			cop_data_ff <= cop_wdata;
		end
	end

	// R01 base saved at instruction start, returned on abort
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			saved_ff <= '0;
			brv_ff <= 1'b0;
			brval_ff <= '0;
		end else begin
			if (mem_start) begin
				saved_ff <= base_in;
			end
			brv_ff <= data_abort;
			brval_ff <= saved_ff;
		end
	end

	// R18 channel flags; a clear wins, and a new event while the flag is set is dropped
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			txv_ff <= 1'b0;
			rxf_ff <= 1'b0;
			tx_ff <= '0;
			rx_ff <= '0;
		end else begin
			txv_ff <= nxt_txv;
			rxf_ff <= nxt_rxf;
			if (dbg_wr && !txv_ff) begin
				tx_ff <= cop_wdata;
			end
			if (dbg_rx_valid && !rxf_ff) begin
				rx_ff <= dbg_rx_data;
			end
		end
	end

	assign cop_done = done_ff;
	assign cop_rdata = rdata_ff;
	assign undefined_trap_access = undef_ff;
	assign ctrl_word = regs_ff[SLOT_CTRL];
	assign cache_op_valid = cop_ff;
	assign cache_op_sel = cop_sel_ff;
	assign cache_op_data = cop_data_ff;
	assign base_restore_valid = brv_ff;
	assign base_restore_value = brval_ff;
	assign dbg_tx_valid = txv_ff;
	assign dbg_tx_data = tx_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	wire sys_rd0 = sys_ok && is_mrc && primary_reg_select == REG_INFO;
	a_user_trap: assert property (take && cop_num == CP_SYS && is_mcr &&
		!cop_priv |=> undefined_trap_access && cop_done) // R02
		else $error("user transfer not trapped");
	a_class_trap: assert property (take && !(is_mcr || is_mrc)
		|=> undefined_trap_access) // R03
		else $error("data op, load or store not trapped");
	a_priv_ok: assert property (take && is_mrc && cop_priv
		|=> cop_done && !undefined_trap_access) // R02
		else $error("privileged read trapped");
	a_id_read: assert property (sys_rd0 && cop_opc2 != OPC2_CACHE_TYPE &&
		cop_opc2 != OPC2_TCM_SIZE |=> cop_rdata == id_word) // R10
		else $error("id word wrong");
	a_type_read: assert property (sys_rd0 && cop_opc2 == OPC2_CACHE_TYPE
		|=> cop_rdata == ct_word) // R19
		else $error("cache type word wrong");
	a_pid_rw: assert property (take && cop_priv && is_mcr &&
		cop_num == CP_SYS && cop_opc1 == 3'h0 &&
		primary_reg_select == REG_PID && secondary_reg_select == 4'h0 &&
		cop_opc2 == 3'h0 |=> regs_ff[SLOT_PID] == $past(cop_wdata)) // R17
		else $error("process_identifier not stored");
	a_reset_clear: assert property (!strap_done_ff |->
		regs_ff[SLOT_PID] == '0 && ctrl_word[CTRL_VEC_BIT-1:0] == '0) // R07
		else $error("state not cleared by reset");
	a_vec_strap: assert property (!strap_done_ff |=>
		ctrl_word[CTRL_VEC_BIT] == $past(vector_high_init_input)) // R08
		else $error("vector bit not loaded");
	a_base_back: assert property (mem_start ##1 (!mem_start && data_abort)
		|=> base_restore_valid &&
		base_restore_value == $past(base_in, 2)) // R01
		else $error("base not restored");
	a_tcm_size: assert property (sys_ok && is_mrc &&
		slot[4:0] == SLOT_TCM_I && slot[5] |=>
		cop_rdata[TCM_SIZE_LSB+TCM_SIZE_W-1:TCM_SIZE_LSB] == ITCM_SIZE) // R16
		else $error("region size not fitted size");
	a_dcc_tx: assert property (dbg_wr && !txv_ff
		|=> dbg_tx_valid && dbg_tx_data == $past(cop_wdata)) // R18
		else $error("comms word not sent");

	a_tcm_read: assert property (sys_rd0 && cop_opc2 == OPC2_TCM_SIZE // R19
		|=> cop_rdata == tcm_word)
		else $error("memory size word wrong");
	a_no_extra_done: assert property (!take |=> !cop_done) // R02
		else $error("done without a request");
	a_write_no_data: assert property (take && is_mcr // R13
		|=> cop_rdata == '0)
		else $error("write returned data");
	a_user_rd_trap: assert property (take && cop_num == CP_SYS && // R03
		is_mrc && !cop_priv |=> undefined_trap_access && cop_rdata == '0)
		else $error("user read not trapped");
	a_trap_no_write: assert property (undef // R03
		|=> $stable(regs_ff[SLOT_PID]))
		else $error("trapped transfer changed state");
	a_ctrl_write: assert property (wr_hit && slot[4:0] == SLOT_CTRL && // R04
		strap_done_ff |=> ctrl_word == $past(cop_wdata))
		else $error("control word not stored");
	a_dtcm_size: assert property (sys_ok && is_mrc && slot[5] && // R16
		slot[4:0] == SLOT_TCM_D |=>
		cop_rdata[TCM_SIZE_LSB+TCM_SIZE_W-1:TCM_SIZE_LSB] == DTCM_SIZE)
		else $error("data region size not fitted size");
	a_cache_op: assert property (cop_wr // R13
		|=> cache_op_valid && cache_op_data == $past(cop_wdata))
		else $error("cache operation not issued");
	a_no_cache_op: assert property (!cop_wr |=> !cache_op_valid) // R13
		else $error("spurious cache operation");
	a_abort_pulse: assert property (!data_abort // R01
		|=> !base_restore_valid)
		else $error("restore without abort");
	a_rx_capture: assert property (dbg_rx_valid && !rxf_ff // R18
		|=> rxf_ff && rx_ff == $past(dbg_rx_data))
		else $error("comms word not received");
	a_tx_clear: assert property (txv_ff && dbg_tx_taken // R18
		|=> !dbg_tx_valid)
		else $error("comms word not released");
	a_dbg_user: assert property (take && cop_num == CP_DBG && // R18
		is_mcr |=> cop_done && !undefined_trap_access)
		else $error("debug channel write trapped");
	c_cache_op: cover property (cop_wr ##1 cache_op_valid);
	c_user_trap: cover property (take && !cop_priv ##1 undefined_trap_access);
	c_abort: cover property (mem_start ##1 data_abort ##1 base_restore_valid);
	c_dcc_rx: cover property (dbg_rx_valid ##1 rxf_ff ##[1:8] dbg_rd_data);
	c_tx_clear: cover property (dbg_tx_valid && dbg_tx_taken ##1 !dbg_tx_valid);
endmodule
`default_nettype wire

// *** scc_pkg.sv ***
// constants of the system control coprocessor register decoder
// assumes a core that presents one coprocessor instruction per cycle
// Notes on behaviour
// R01: on data abort the base register returns to its pre-instruction value
// R02: system control space reachable only by privileged register transfers
// R03: data ops, loads, stores and user-mode transfers take undefined trap
// R04: primary register select picks one of sixteen register numbers
// R05: secondary register and secondary opcode pick a register within a number
// R06: software keeps unused opcode and secondary fields at zero
// R07: reset clears every defined stateful register bit
// R08: vector location bit loads the vector-high input at reset
// R09: register 0 read-only; opcode picks id, cache type or memory size
// R10: register 0 returns the id word for opcodes other than one and two
// R11: id word holds maker, variant, architecture four, part, revision
// R12: registers 2, 5 and 9 hold separate instruction and data registers
// R13: registers without reads may return anything; register 7 is write-only
// R14: no access of any value may damage the device
// R15: software writes ones to write-as-ones and zeros to write-as-zeros
// R16: register 9 memory sizes match the fitted local memories
// R17: register 13 holds a readable and writable process identifier
// R18: debug coprocessor 14 gives access to the debug comms channel
// R19: register 0 opcode one gives cache type, two gives memory size
// R20: every transferred register is a 32-bit word
package scc_pkg;
	localparam int WORD_W = 32;
	localparam logic [3:0] CP_SYS = 4'hF;
	localparam logic [3:0] CP_DBG = 4'hE;
	localparam logic [2:0] K_CORE_TO_COPROC_MOVE = 3'h0;
	localparam logic [2:0] K_COPROC_TO_CORE_MOVE = 3'h1;
	localparam logic [2:0] K_COPROC_DATA_OPERATION = 3'h2;
	localparam logic [2:0] K_COPROC_LOAD = 3'h3;
	localparam logic [2:0] K_COPROC_STORE = 3'h4;
	localparam logic [3:0] REG_INFO = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h1;
	localparam logic [3:0] REG_CFG = 4'h2;
	localparam logic [3:0] REG_WB = 4'h3;
	localparam logic [3:0] REG_AP = 4'h5;
	localparam logic [3:0] REG_REGION = 4'h6;
	localparam logic [3:0] REG_CACHEOP = 4'h7;
	localparam logic [3:0] REG_LOCK = 4'h9;
	localparam logic [3:0] REG_PID = 4'hD;
	localparam logic [3:0] REG_TEST = 4'hF;
	localparam logic [2:0] OPC2_CACHE_TYPE = 3'h1;
	localparam logic [2:0] OPC2_TCM_SIZE = 3'h2;
	localparam logic [3:0] ID_ARCH = 4'h4;
	localparam logic [3:0] CT_CLASS = 4'h7;
	localparam logic [1:0] CT_LINE8 = 2'h2;
	localparam logic [2:0] ASSOC_4WAY = 3'h2;
	localparam logic [2:0] ASSOC_NONE = 3'h0;
	localparam logic [3:0] SIZE_MAX = 4'hB;
	localparam int CTRL_VEC_BIT = 13;
	localparam int TCM_SIZE_LSB = 1;
	localparam int TCM_SIZE_W = 4;
	localparam logic [4:0] SLOT_CTRL = 5'h00;
	localparam logic [4:0] SLOT_CFG_D = 5'h01;
	localparam logic [4:0] SLOT_WB = 5'h03;
	localparam logic [4:0] SLOT_AP_D = 5'h04;
	localparam logic [4:0] SLOT_REGION0 = 5'h06;
	localparam logic [4:0] SLOT_LOCK_D = 5'h0E;
	localparam logic [4:0] SLOT_TCM_D = 5'h10;
	localparam logic [4:0] SLOT_TCM_I = 5'h11;
	localparam logic [4:0] SLOT_PID = 5'h12;
	localparam logic [4:0] SLOT_BIST = 5'h13;
	localparam int NUM_SLOTS = 22;
	localparam logic [3:0] DBG_STATUS = 4'h0;
	localparam logic [3:0] DBG_DATA = 4'h1;
endpackage

// *** core_model.sv ***
// core-side model issuing coprocessor register transfers
// assumes a free-running mclk and cop_done within four cycles
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic mclk,
	input wire logic cop_done,
	input wire logic [31:0] cop_rdata,
	input wire logic undefined_trap_access,
	output logic cop_valid,
	output logic [2:0] cop_kind,
	output logic [3:0] cop_num,
	output logic [2:0] cop_opc1,
	output logic [3:0] primary_reg_select,
	output logic [3:0] secondary_reg_select,
	output logic [2:0] cop_opc2,
	output logic cop_priv,
	output logic [31:0] cop_wdata
);
	initial begin
		{cop_valid, cop_kind, cop_num, cop_opc1, cop_opc2, cop_priv} = '0;
		{primary_reg_select, secondary_reg_select, cop_wdata} = '0;
	end
	task automatic xfer(input logic [2:0] k, input logic [3:0] n,
		input logic [3:0] rs, input logic [3:0] ss, input logic [2:0] o2,
		input logic pv, input logic [31:0] wd, output logic [31:0] rd,
		output logic trap, output logic ok);
		@(posedge mclk);
		#1;
		{cop_kind, cop_num, primary_reg_select} = {k, n, rs};
		{secondary_reg_select, cop_opc2, cop_priv} = {ss, o2, pv};
		cop_opc1 = 3'h0;
		cop_wdata = wd;
		cop_valid = 1'b1;
		@(posedge mclk);
		#1;
		cop_valid = 1'b0;
		// released data changes so a stale word is never mistaken for live
		cop_wdata = ~wd;
		{rd, trap, ok} = '0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (cop_done === 1'b1) begin
				{rd, trap, ok} = {cop_rdata, undefined_trap_access, 1'b1};
			end else begin
				@(posedge mclk);
				#1;
			end
		end
	endtask
endmodule
`default_nettype wire

// *** system_control_coproc_regmap_bench.sv ***
// self-checking bench of the system control coprocessor decoder
// assumes core_model makes the transfers; other inputs are driven here
`timescale 1ns/1ps
`default_nettype none
module system_control_coproc_regmap_bench;
	import scc_pkg::*;
	localparam logic [2:0] KW = K_CORE_TO_COPROC_MOVE;
	localparam logic [2:0] KR = K_COPROC_TO_CORE_MOVE;
	// maker 5A and part 123 are the arbitrary default identity values
	localparam logic [31:0] ID_W = {8'h5A, 4'h1, ID_ARCH, 12'h123, 4'h2};
	localparam logic [31:0] CT_W = {3'h0, CT_CLASS, 1'b1, 2'h0, 4'h4,
		ASSOC_4WAY, 1'b0, CT_LINE8, 2'h0, 4'h6, ASSOC_4WAY, 1'b0, CT_LINE8};
	localparam logic [31:0] TM_W = {10'h0, 4'h5, 8'h0, 4'h7, 6'h0};
	localparam logic [10:0] RW_SEL [6] = '{{REG_CTRL, 7'h00},
		{REG_WB, 7'h00}, {REG_REGION, 4'h7, 3'h0}, {REG_REGION, 7'h00},
		{REG_LOCK, 4'h0, 3'h1}, {REG_TEST, 4'h0, 3'h2}};
	localparam logic [3:0] UNR [6] = '{4'h4, 4'h7, 4'h8, 4'hA, 4'hB, 4'hC};
	logic mclk = 1'b0;
	logic sys_rst, vector_high_init_input, mem_start, data_abort, trap, ok;
	logic dbg_rx_valid, dbg_tx_taken, cop_valid, cop_priv, cop_done;
	logic undefined_trap_access, cache_op_valid, base_restore_valid;
	logic dbg_tx_valid;
	logic [2:0] cop_kind, cop_opc1, cop_opc2;
	logic [3:0] cop_num, primary_reg_select, secondary_reg_select, r;
	logic [6:0] cache_op_sel;
	logic [31:0] base_in, dbg_rx_data, rd, cop_wdata, cop_rdata, ctrl_word;
	logic [31:0] cache_op_data, base_restore_value, dbg_tx_data;
	int n_fail = 0;
	int check_count = 0;
	always #2 mclk = ~mclk;
	system_control_coproc_regmap #(.VARIANT(4'h1), .REVISION(4'h2),
		.ICACHE_SIZE(4'h6), .DCACHE_SIZE(4'h4), .ITCM_SIZE(4'h7)
	) system_control_coproc_regmap_i (.mclk, .sys_rst,
		.vector_high_init_input, .cop_valid, .cop_kind, .cop_num, .cop_opc1,
		.primary_reg_select, .secondary_reg_select, .cop_opc2, .cop_priv,
		.cop_wdata, .cop_done, .cop_rdata, .undefined_trap_access, .ctrl_word,
		.cache_op_valid, .cache_op_sel, .cache_op_data, .mem_start, .base_in,
		.data_abort, .base_restore_valid, .base_restore_value, .dbg_rx_valid,
		.dbg_rx_data, .dbg_tx_taken, .dbg_tx_valid, .dbg_tx_data);
	core_model core_model_i (.mclk, .cop_done, .cop_rdata,
		.undefined_trap_access, .cop_valid, .cop_kind, .cop_num, .cop_opc1,
		.primary_reg_select, .secondary_reg_select, .cop_opc2, .cop_priv,
		.cop_wdata);
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic op(logic [2:0] k, logic [3:0] n, logic [3:0] rs,
		logic [3:0] ss, logic [2:0] o2, logic pv, logic [31:0] wd);
		core_model_i.xfer(k, n, rs, ss, o2, pv, wd, rd, trap, ok);
		if (ok !== 1'b1) begin
			check("done", 32'h0, 32'h1);
			complete_run();
		end
	endtask
	task automatic rs(logic [3:0] rg, logic [3:0] s, logic [2:0] o);
		op(KR, CP_SYS, rg, s, o, 1'b1, '0);
	endtask
	task automatic ws(logic [3:0] rg, logic [2:0] o, logic [31:0] d);
		op(KW, CP_SYS, rg, 4'h0, o, 1'b1, d);
	endtask
	task automatic rst(logic v);
		sys_rst = 1'b1;
		vector_high_init_input = v;
		repeat (5) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	initial begin
		{mem_start, data_abort, dbg_rx_valid, dbg_tx_taken} = '0;
		{base_in, dbg_rx_data} = '0;
		rst(1'b1);
		check("ctrl", ctrl_word, 32'h0000_2000);
		rs(REG_PID, 4'h0, 3'h0);
		check("pid", rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rs(REG_INFO, 4'h0, 3'(i));
			check("info", rd, i == 1 ? CT_W : i == 2 ? TM_W : ID_W);
		end
		ws(REG_INFO, 3'h0, 32'hFFFF_FFFF);
		rs(REG_INFO, 4'h0, 3'h0);
		check("id", rd, ID_W);
		$display("test identification done");
		for (int j = 0; j < 2; j++) begin
			r = j ? REG_AP : REG_CFG;
			ws(r, 3'h0, 32'h5A5A_0F0F);
			ws(r, 3'h1, 32'hA5A5_F0F0);
			rs(r, 4'h0, 3'h0);
			check("data side", rd, 32'h5A5A_0F0F);
			rs(r, 4'h0, 3'h1);
			check("instr side", rd, 32'hA5A5_F0F0);
		end
		rs(REG_LOCK, 4'h1, 3'h0);
		check("dtcm size", {28'h0, rd[4:1]}, 32'h5);
		rs(REG_LOCK, 4'h1, 3'h1);
		check("itcm size", {28'h0, rd[4:1]}, 32'h7);
		ws(REG_PID, 3'h0, 32'hC3A5_9600);
		rs(REG_PID, 4'h0, 3'h0);
		check("pid", rd, 32'hC3A5_9600);
		foreach (RW_SEL[i]) begin
			op(KW, CP_SYS, RW_SEL[i][10:7], RW_SEL[i][6:3], RW_SEL[i][2:0],
				1'b1, 32'h1234_5670 + 32'(i));
		end
		foreach (RW_SEL[i]) begin
			rs(RW_SEL[i][10:7], RW_SEL[i][6:3], RW_SEL[i][2:0]);
			check("rw slot", rd, 32'h1234_5670 + 32'(i));
		end
		check("ctrl out", ctrl_word, 32'h1234_5670);
		$display("test storage done");
		for (int k = 2; k < 5; k++) begin
			op(3'(k), CP_SYS, REG_PID, 4'h0, 3'h0, 1'b1, '0);
			check("trap kind", {31'h0, trap}, 32'h1);
		end
		op(KW, CP_SYS, REG_PID, 4'h0, 3'h0, 1'b0, 32'h1);
		check("user trap", {31'h0, trap}, 32'h1);
		op(KR, CP_SYS, REG_PID, 4'h0, 3'h0, 1'b0, '0);
		check("user rd trap", {rd[31:1], trap}, 32'h1);
		rs(REG_PID, 4'h0, 3'h0);
		check("pid kept", rd, 32'hC3A5_9600);
		foreach (UNR[i]) begin
			rs(UNR[i], 4'h0, 3'h0);
			check("unmapped", {rd[31:1], rd[0] | trap}, 32'h0);
		end
		op(KW, CP_SYS, REG_CACHEOP, 4'h5, 3'h1, 1'b1, 32'h0000_1240);
		check("cache op", {cache_op_valid, cache_op_sel, cache_op_data[23:0]},
			{1'b1, 7'h29, 24'h00_1240});
		$display("test traps done");
		@(posedge mclk);
		#1;
		{mem_start, base_in} = {1'b1, 32'h0000_4000};
		@(posedge mclk);
		#1;
		{mem_start, data_abort, base_in} = {2'b01, 32'h0000_4010};
		@(posedge mclk);
		#1;
		check("restore", base_restore_value, 32'h0000_4000);
		check("restore vld", {31'h0, base_restore_valid}, 32'h1);
		{mem_start, data_abort, base_in} = {2'b11, 32'h0000_5000};
		@(posedge mclk);
		#1;
		check("restore old", base_restore_value, 32'h0000_4000);
		{mem_start, data_abort, base_in} = {2'b00, 32'hFFFF_BFEF};
		{dbg_rx_valid, dbg_rx_data} = {1'b1, 32'h600D_F00D};
		@(posedge mclk);
		#1;
		{dbg_rx_valid, dbg_rx_data} = {1'b0, 32'h9FF2_0FF2};
		op(KR, CP_DBG, DBG_STATUS, 4'h0, 3'h0, 1'b0, '0);
		check("rx full", rd, 32'h1);
		op(KR, CP_DBG, DBG_DATA, 4'h0, 3'h0, 1'b0, '0);
		check("rx data", rd, 32'h600D_F00D);
		op(KW, CP_DBG, DBG_DATA, 4'h0, 3'h0, 1'b0, 32'h0BAD_CAFE);
		check("tx", {dbg_tx_valid, dbg_tx_data[30:0]}, 32'h8BAD_CAFE);
		op(KR, CP_DBG, DBG_STATUS, 4'h0, 3'h0, 1'b0, '0);
		check("tx pend", rd, 32'h2);
		dbg_tx_taken = 1'b1;
		@(posedge mclk);
		#1;
		dbg_tx_taken = 1'b0;
		check("tx clr", {31'h0, dbg_tx_valid}, 32'h0);
		$display("test abort and debug done");
		rst(1'b0);
		check("ctrl rst", ctrl_word, 32'h0);
		rs(REG_PID, 4'h0, 3'h0);
		check("pid rst", rd, 32'h0);
		$display("test second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
